// [hdl/nfc_defines.vh]
// Constants for the NAND host controller
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH
`define NFC_CMD_READ_A        8'h00
`define NFC_CMD_READ_B        8'h01
`define NFC_CMD_READ_SPARE    8'h50
`define NFC_CMD_PROG_SETUP    8'h80
`define NFC_CMD_PROG_CONFIRM  8'h10
`define NFC_CMD_ERASE_SETUP   8'h60
`define NFC_CMD_ERASE_CONFIRM 8'hD0
`define NFC_CMD_STATUS        8'h70
`define NFC_CMD_ID            8'h90
`define NFC_CMD_RESET         8'hFF
`define NFC_ID_ADDR           8'h00
`define NFC_OFF_CTRL          12'h000
`define NFC_OFF_ADDR          12'h004
`define NFC_OFF_WDATA         12'h008
`define NFC_OFF_RDATA         12'h00C
`define NFC_OFF_STAT          12'h010
`define NFC_OFF_PWRUP         12'h014
`define NFC_OP_CMD            3'h1
`define NFC_OP_ADDR           3'h2
`define NFC_OP_WDATA          3'h3
`define NFC_OP_RDATA          3'h4
`define NFC_OP_WAITRB         3'h5
`define NFC_OP_CEHIGH         3'h6
`define NFC_STROBE_NS         12
`define NFC_STROBE_CYC        ((`NFC_STROBE_NS + 3) / 4)
`define NFC_PWRUP_US          10
`define NFC_PWRUP_CYC         ((`NFC_PWRUP_US * 1000 + 3) / 4)
`define NFC_PAGE_BYTES        528
`define NFC_MAIN_PROG_MAX     2
`define NFC_SPARE_PROG_MAX    3
`define NFC_STATUS_RESET      8'hC0
`endif

// [hdl/nfc_host.v]
// APB-programmed host controller driving a small-page NAND flash over its pins
`timescale 1ns/1ns
`include "nfc_defines.vh"
module nfc_host (
   clk,
   rst_b,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   ce_n,
   cle,
   ale,
   we_n,
   read_strobe_n,
   wp_n,
   io_out,
   io_oe_n,
   io_in,
   rb_in
);
   input             clk;
   input             rst_b;
   input             psel;
   input             penable;
   input             pwrite;
   input      [11:0] paddr;
   input      [31:0] pwdata;
   output reg [31:0] prdata;
   output reg        pready;
   output reg        pslverr;
   output reg        ce_n;
   output reg        cle;
   output reg        ale;
   output reg        we_n;
   output reg        read_strobe_n;
   output reg        wp_n;
   output reg  [7:0] io_out;
   output reg        io_oe_n;
   input       [7:0] io_in;
   input             rb_in;

   localparam [2:0] H_IDLE  = 3'h0;
   localparam [2:0] H_SETUP = 3'h1;
   localparam [2:0] H_PULSE = 3'h2;
   localparam [2:0] H_WAIT  = 3'h3;
   localparam [2:0] H_RB    = 3'h4;

   reg  [2:0]  state_reg;
   reg  [2:0]  op_reg;
   reg  [7:0]  byte_reg;
   reg  [7:0]  rdata_reg;
   reg  [7:0]  last_cmd_reg;
   reg         cmd_err_reg;
   reg         busy_reg;
   reg         hold_ce_reg;
   reg  [11:0] pwr_cnt_reg;
   reg         pwr_ok_reg;
   reg  [1:0]  main_prog_reg;
   reg  [1:0]  spare_prog_reg;
   reg  [9:0]  prog_bytes_reg;
   reg         data_seen_reg;
   // Pointer copy so spare partial programs are counted apart from main ones
   reg         spare_ptr_reg;
   reg         strobe_go;
   reg         strobe_rd;
   wire        str_n;
   wire        str_sample;
   wire        str_done;

   // Decode shared by the APB write path and the io_oe_n drive enable
   function is_write_strobe;
      input [2:0] op;
      begin
         is_write_strobe = (op == `NFC_OP_CMD) || (op == `NFC_OP_ADDR) || (op == `NFC_OP_WDATA);
      end
   endfunction

   nfc_strobe u_strobe (
      .clk      (clk),
      .rst_b    (rst_b),
      .start    (strobe_go),
      .is_read  (strobe_rd),
      .strobe_n (str_n),
      .sample   (str_sample),
      .done     (str_done)
   );

   wire apb_wr_ctrl = psel && penable && pwrite && (paddr == `NFC_OFF_CTRL) && !pready;
   wire [2:0] req_op = pwdata[10:8];
   wire [7:0] req_byte = pwdata[7:0];
   // While busy with program or erase only status and reset commands pass; address and data ops are not blocked
   wire cmd_blocked = busy_reg && (req_op == `NFC_OP_CMD) &&
                      (req_byte != `NFC_CMD_STATUS) && (req_byte != `NFC_CMD_RESET);
   wire confirm_empty = (req_op == `NFC_OP_CMD) && (req_byte == `NFC_CMD_PROG_CONFIRM) &&
                        !data_seen_reg;
   // Page register holds one page; a longer burst would wrap onto loaded bytes
   wire data_overrun = (req_op == `NFC_OP_WDATA) && (prog_bytes_reg == `NFC_PAGE_BYTES);
   // Device drops a second reset while the first runs, so refuse it here
   wire reset_repeat = (req_op == `NFC_OP_CMD) && (req_byte == `NFC_CMD_RESET) &&
                       (last_cmd_reg == `NFC_CMD_RESET) && busy_reg;
   wire req_bad = !pwr_ok_reg || cmd_blocked || confirm_empty || data_overrun || reset_repeat;

   always @(posedge clk) begin
      if (!rst_b) begin
         pwr_cnt_reg <= 12'h000;
         pwr_ok_reg  <= 1'b0;
         wp_n        <= 1'b0;
      end else if (!pwr_ok_reg) begin
         // Write protect low through the power-up wait
         if (pwr_cnt_reg == `NFC_PWRUP_CYC - 1) begin
            pwr_ok_reg <= 1'b1;
            wp_n       <= 1'b1;
         end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 12'h001;
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         state_reg      <= H_IDLE;
         op_reg         <= 3'h0;
         byte_reg       <= 8'h00;
         rdata_reg      <= 8'hFF;
         last_cmd_reg   <= `NFC_CMD_READ_A;
         cmd_err_reg    <= 1'b0;
         busy_reg       <= 1'b0;
         hold_ce_reg    <= 1'b0;
         main_prog_reg  <= 2'h0;
         spare_prog_reg <= 2'h0;
         prog_bytes_reg <= 10'h000;
         data_seen_reg  <= 1'b0;
         spare_ptr_reg  <= 1'b0;
         strobe_go      <= 1'b0;
         strobe_rd      <= 1'b0;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         prdata         <= 32'h0000_0000;
         ce_n           <= 1'b1;
         cle            <= 1'b0;
         ale            <= 1'b0;
         we_n           <= 1'b1;
         read_strobe_n  <= 1'b1;
         io_out         <= 8'h00;
         io_oe_n        <= 1'b1;
      end else begin
         strobe_go <= 1'b0;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         we_n          <= (state_reg == H_PULSE && !strobe_rd) ? str_n : 1'b1;
         read_strobe_n <= (state_reg == H_PULSE && strobe_rd) ? str_n : 1'b1;
         if (str_sample)
            rdata_reg <= io_in;
         case (state_reg)
            H_IDLE: begin
               if (apb_wr_ctrl) begin
                  if (req_bad) begin
                     cmd_err_reg <= 1'b1;
                     pready      <= 1'b1;
                     pslverr     <= 1'b1;
                  end else if (req_op == `NFC_OP_CEHIGH) begin
                     // Ends a sequential row read and leaves the pins idle
                     ce_n        <= 1'b1;
                     hold_ce_reg <= 1'b0;
                     pready      <= 1'b1;
                  end else if (is_write_strobe(req_op) || req_op == `NFC_OP_RDATA ||
                               req_op == `NFC_OP_WAITRB) begin
                     op_reg    <= req_op;
                     byte_reg  <= req_byte;
                     ce_n      <= 1'b0;
                     hold_ce_reg <= pwdata[16];
                     cle       <= (req_op == `NFC_OP_CMD);
                     ale       <= (req_op == `NFC_OP_ADDR);
                     io_out    <= req_byte;
                     io_oe_n   <= !is_write_strobe(req_op);
                     state_reg <= (req_op == `NFC_OP_WAITRB) ? H_RB : H_SETUP;
                  end else begin
                     pready  <= 1'b1;
                     pslverr <= 1'b1;
                  end
               end
            end
            H_SETUP: begin
               // Latch lines and byte settle three cycles before the strobe falls
               strobe_go <= 1'b1;
               strobe_rd <= (op_reg == `NFC_OP_RDATA);
               state_reg <= H_PULSE;
            end
            H_PULSE: begin
               if (str_done) begin
                  state_reg <= H_WAIT;
                  cle       <= 1'b0;
                  ale       <= 1'b0;
                  io_oe_n   <= 1'b1;
                  if (!hold_ce_reg)
                     ce_n <= 1'b1;
                  if (op_reg == `NFC_OP_CMD) begin
                     // Kept readable so software knows when status mode is still on
                     last_cmd_reg <= byte_reg;
                     case (byte_reg)
                        `NFC_CMD_READ_A, `NFC_CMD_READ_B: spare_ptr_reg <= 1'b0;
                        `NFC_CMD_READ_SPARE: spare_ptr_reg <= 1'b1;
                        `NFC_CMD_PROG_SETUP: begin
                           prog_bytes_reg <= 10'h000;
                           data_seen_reg  <= 1'b0;
                        end
                        `NFC_CMD_PROG_CONFIRM: begin
                           busy_reg      <= 1'b1;
                           data_seen_reg <= 1'b0;
                           if (spare_ptr_reg)
                              spare_prog_reg <= spare_prog_reg + 2'h1;
                           else
                              main_prog_reg <= main_prog_reg + 2'h1;
                        end
                        `NFC_CMD_ERASE_CONFIRM: begin
                           busy_reg       <= 1'b1;
                           main_prog_reg  <= 2'h0;
                           spare_prog_reg <= 2'h0;
                        end
                        `NFC_CMD_RESET: begin
                           // Device clears its address pointer on reset
                           busy_reg      <= 1'b1;
                           spare_ptr_reg <= 1'b0;
                        end
                        default: ;
                     endcase
                  end
                  if (op_reg == `NFC_OP_WDATA) begin
                     prog_bytes_reg <= prog_bytes_reg + 10'h001;
                     data_seen_reg  <= 1'b1;
                  end
               end
            end
            H_RB: begin
               // Open-drain ready/busy, high means the device finished
               if (rb_in) begin
                  busy_reg  <= 1'b0;
                  if (!hold_ce_reg)
                     ce_n <= 1'b1;
                  state_reg <= H_WAIT;
               end
            end
            H_WAIT: begin
               pready    <= 1'b1;
               state_reg <= H_IDLE;
            end
            default: state_reg <= H_IDLE;
         endcase
         // Register reads and the flag clear answer in one cycle, pins untouched
         if (psel && penable && !pready && !apb_wr_ctrl && state_reg == H_IDLE) begin
            pready <= 1'b1;
            if (!pwrite) begin
               case (paddr)
                  `NFC_OFF_RDATA: prdata <= {24'h000000, rdata_reg};
                  `NFC_OFF_STAT:  prdata <= {24'h000000, last_cmd_reg};
                  `NFC_OFF_PWRUP: prdata <= {20'h00000, main_prog_reg, spare_prog_reg,
                                             prog_bytes_reg[7:0]};
                  `NFC_OFF_CTRL:  prdata <= {25'h0000000, !rb_in, busy_reg, 1'b0,
                                             cmd_err_reg, !pwr_ok_reg, state_reg != H_IDLE, hold_ce_reg};
                  default: begin
                     prdata  <= 32'h0000_0000;
                     pslverr <= 1'b1;
                  end
               endcase
            end else if (paddr == `NFC_OFF_STAT) begin
               if (pwdata[0])
                  cmd_err_reg <= 1'b0;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule // nfc_host

// [hdl/nfc_strobe.v]
// One pin cycle: a write or read strobe pulse with fixed low and high times
`timescale 1ns/1ns
`include "nfc_defines.vh"
module nfc_strobe (
   clk,
   rst_b,
   start,
   is_read,
   strobe_n,
   sample,
   done
);
   input            clk;
   input            rst_b;
   input            start;
   input            is_read;
   output reg       strobe_n;
   output reg       sample;
   output reg       done;

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_LOW  = 2'h1;
   localparam [1:0] S_HIGH = 2'h2;

   reg [1:0] state_reg;
   reg [3:0] cnt_reg;
   reg       rd_reg;

   always @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= S_IDLE;
         cnt_reg   <= 4'h0;
         rd_reg    <= 1'b0;
         strobe_n  <= 1'b1;
         sample    <= 1'b0;
         done      <= 1'b0;
      end else begin
         sample <= 1'b0;
         done   <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (start) begin
                  state_reg <= S_LOW;
                  rd_reg    <= is_read;
                  strobe_n  <= 1'b0;
                  cnt_reg   <= 4'h0;
               end
            end
            S_LOW: begin
               if (cnt_reg == `NFC_STROBE_CYC - 1) begin
                  // Read data settled by now, sample before the rising edge
                  sample    <= rd_reg;
                  strobe_n  <= 1'b1;
                  state_reg <= S_HIGH;
                  cnt_reg   <= 4'h0;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            S_HIGH: begin
               if (cnt_reg == `NFC_STROBE_CYC - 1) begin
                  done      <= 1'b1;
                  state_reg <= S_IDLE;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule // nfc_strobe

// [testbench/nfc_host_chk.sv]
// Port assertions for the NAND host controller
`timescale 1ns/1ns
module nfc_host_chk (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       ce_n,
   input wire logic       cle,
   input wire logic       ale,
   input wire logic       we_n,
   input wire logic       read_strobe_n,
   input wire logic       wp_n,
   input wire logic [7:0] io_out,
   input wire logic       io_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr outside a completed transfer");
   AST_WE_SELECTED: assert property (!we_n |-> !ce_n && !io_oe_n)
      else $error("write strobe without select or bus drive");
   AST_LATCH_EXCL: assert property (!(cle && ale))
      else $error("command and address latch both high");
   AST_RD_NO_DRIVE: assert property (!read_strobe_n |-> io_oe_n && !ce_n && we_n)
      else $error("read strobe while host drives the bus");
   AST_WE_PULSE: assert property ($fell(we_n) |=> !we_n [*2] ##1 we_n [*3])
      else $error("write strobe low or high time wrong");
   AST_RE_PULSE: assert property ($fell(read_strobe_n) |=> !read_strobe_n [*2] ##1 read_strobe_n [*3])
      else $error("read strobe low or high time wrong");
   AST_WE_HOLD: assert property (!we_n |=> $stable(io_out) && $stable(cle) && $stable(ale))
      else $error("byte or latch lines moved under the write strobe");
   AST_WP_POWERUP: assert property ($rose(rst_b) |-> !wp_n [*8])
      else $error("write protect released too early");
endmodule // nfc_host_chk
bind nfc_host nfc_host_chk u_chk (.clk(clk), .rst_b(rst_b), .pready(pready), .pslverr(pslverr),
   .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
   .io_out(io_out), .io_oe_n(io_oe_n));

// [testbench/nfc_nand_model.sv]
// Behavioural small-page NAND device facing the host controller
`timescale 1ns/1ns
module nfc_nand_model #(
   parameter logic [7:0] MFR     = 8'h5A, // Arbitrary value
   parameter logic [7:0] DEV     = 8'hA5, // Arbitrary value
   parameter int         LOAD_NS = 400,
   parameter int         BUSY_NS = 2000,
   parameter int         RST_NS  = 1000
) (
   input wire logic       ce_n,
   input wire logic       cle,
   input wire logic       ale,
   input wire logic       we_n,
   input wire logic       read_strobe_n,
   input wire logic       wp_n,
   input wire logic [7:0] io_out,
   output logic     [7:0] io_in,
   output logic           rb_in
);
   logic [7:0] mem [0:527];
   logic [7:0] cmd = 8'h00;
   logic [9:0] base = 10'h000;
   logic [9:0] col = 10'h000;
   int         acnt = 0;
   int         idx = 0;
   logic       loaded = 1'h0;
   logic       busy = 1'h0;
   time        bend = 0;
   time        rend = 0;
   initial io_in = 8'h00;
   initial for (int i = 0; i < 528; i++) mem[i] = 8'hFF;
   always #1 busy = $time < bend;
   assign rb_in = busy ? 1'h0 : 1'h1; // Open drain, pull-up when idle
   always @(posedge we_n) if (!ce_n) begin
      if (cle) begin
         if (!busy || io_out == 8'h70 || io_out == 8'hFF) begin
            cmd = io_out;
            acnt = 0;
            idx = 0;
            case (io_out)
               8'h00, 8'h01, 8'h50: base = {io_out[6], io_out[0], 8'h00};
               8'h80: loaded = 1'h0;
               8'h10: if (loaded) bend = $time + BUSY_NS;
               8'hD0: begin
                  for (int i = 0; i < 528; i++) mem[i] = 8'hFF;
                  bend = $time + BUSY_NS;
               end
               8'hFF: if ($time >= rend) begin
                  bend = $time + RST_NS;
                  rend = bend;
                  base = 10'h000;
               end
               default: ;
            endcase
         end
      end else if (ale) begin
         if (acnt == 0) col = (base == 10'h200) ? {6'h20, io_out[3:0]} : base + {2'h0, io_out};
         acnt++;
         if (acnt == 3 && cmd != 8'h80) begin
            bend = $time + LOAD_NS;
            if (base == 10'h100) base = 10'h000;
         end
      end else if (cmd == 8'h80) begin
         mem[col] = io_out;
         col++;
         loaded = 1'h1;
      end
   end
   always @(negedge read_strobe_n) if (!ce_n) begin
      if (cmd == 8'h70) io_in = {wp_n, !busy, 6'h00};
      else if (cmd == 8'h90) begin
         io_in = (idx == 0) ? MFR : DEV;
         idx = 1;
      end else begin
         io_in = mem[col];
         if (col < 10'h20F) col++;
         else begin
            col = (base == 10'h200) ? 10'h200 : 10'h000;
            bend = $time + LOAD_NS;
         end
      end
   end
   // Data goes stale once the hold time has run out
   always @(posedge read_strobe_n) #8 io_in = ~io_in;
endmodule // nfc_nand_model

// [testbench/tb_nfc_host.sv]
// Self-checking bench for the NAND host controller
`timescale 1ns/1ns
module tb_nfc_host;
   localparam logic [7:0] MFR = 8'h5A; // Arbitrary value
   localparam logic [7:0] DEV = 8'hA5; // Arbitrary value
   logic        clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic        pready, pslverr, ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe_n, rb_in, e;
   logic [7:0]  io_out, io_in;
   int          errors = 0, comparisons = 0;
   always #2 clk = ~clk;
   nfc_host dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
      .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in), .rb_in(rb_in));
   nfc_nand_model #(.MFR(MFR), .DEV(DEV)) mdl (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_in(io_in), .rb_in(rb_in));
   task automatic test_done;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 9000);
      if (n >= 9000) begin
         errors++;
         test_done;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic op(input logic [2:0] o, input logic [7:0] b, input logic x);
      apb(1'h1, 12'h000, {21'h000000, o, b});
      chk("refusal", e, x);
   endtask
   task automatic a3(input logic [7:0] c);
      op(3'h2, c, 1'h0);
      op(3'h2, 8'h00, 1'h0);
      op(3'h2, 8'h00, 1'h0);
   endtask
   task automatic rdb(input string nm, input logic [7:0] x);
      op(3'h4, 8'h00, 1'h0);
      apb(1'h0, 12'h00C, 32'h0000_0000);
      chk(nm, q[7:0], x);
   endtask
   task automatic t_pwr;
      chk("ce_n idle", ce_n, 1'h1);
      chk("wp_n at start", wp_n, 1'h0);
      op(3'h1, 8'h00, 1'h1);
      apb(1'h0, 12'h000, 32'h0000_0000);
      chk("power wait flag", q[2], 1'h1);
      repeat (2600) @(posedge clk);
      chk("wp_n released", wp_n, 1'h1);
   endtask
   task automatic t_id;
      op(3'h1, 8'h90, 1'h0);
      op(3'h2, 8'h00, 1'h0);
      rdb("maker code", MFR);
      rdb("device code", DEV);
   endtask
   task automatic t_prog;
      op(3'h1, 8'h00, 1'h0);
      op(3'h1, 8'h80, 1'h0);
      a3(8'h04);
      op(3'h3, 8'hA1, 1'h0);
      op(3'h3, 8'hB2, 1'h0);
      op(3'h1, 8'h10, 1'h0);
      op(3'h5, 8'h00, 1'h0);
      op(3'h1, 8'h70, 1'h0);
      rdb("status after program", 8'hC0);
      op(3'h1, 8'h00, 1'h0);
      a3(8'h04);
      op(3'h5, 8'h00, 1'h0);
      apb(1'h1, 12'h000, 32'h0001_0400);
      chk("held read refusal", e, 1'h0);
      chk("ce_n held low", ce_n, 1'h0);
      apb(1'h0, 12'h00C, 32'h0000_0000);
      chk("page byte 4", q[7:0], 8'hA1);
      apb(1'h0, 12'h000, 32'h0000_0000);
      chk("hold flag", q[1:0], 2'h1);
      op(3'h6, 8'h00, 1'h0);
      chk("ce_n released", ce_n, 1'h1);
      rdb("page byte 5", 8'hB2);
      rdb("page byte 6", 8'hFF);
   endtask
   task automatic t_spare;
      op(3'h1, 8'h50, 1'h0);
      op(3'h1, 8'h80, 1'h0);
      a3(8'h03);
      op(3'h3, 8'h5E, 1'h0);
      op(3'h1, 8'h10, 1'h0);
      op(3'h5, 8'h00, 1'h0);
      op(3'h1, 8'h50, 1'h0);
      a3(8'hF3);
      op(3'h5, 8'h00, 1'h0);
      rdb("spare byte 515", 8'h5E);
      apb(1'h0, 12'h014, 32'h0000_0000);
      chk("partial program counts", q, 32'h0000_0501);
   endtask
   task automatic t_nodata;
      op(3'h1, 8'h80, 1'h0);
      a3(8'h00);
      op(3'h1, 8'h10, 1'h1);
      apb(1'h0, 12'h000, 32'h0000_0000);
      chk("error flag set", q[3], 1'h1);
      apb(1'h1, 12'h010, 32'h0000_0001);
      apb(1'h0, 12'h000, 32'h0000_0000);
      chk("error flag cleared", q[3], 1'h0);
   endtask
   task automatic t_erase;
      op(3'h1, 8'h60, 1'h0);
      op(3'h2, 8'h00, 1'h0);
      op(3'h2, 8'h00, 1'h0);
      op(3'h1, 8'hD0, 1'h0);
      op(3'h1, 8'h00, 1'h1);
      op(3'h1, 8'h70, 1'h0);
      rdb("status while busy", 8'h80);
      op(3'h5, 8'h00, 1'h0);
      op(3'h1, 8'h00, 1'h0);
      a3(8'h04);
      op(3'h5, 8'h00, 1'h0);
      rdb("erased byte", 8'hFF);
      apb(1'h0, 12'h014, 32'h0000_0000);
      chk("counts after erase", q, 32'h0000_0000);
   endtask
   task automatic t_rst;
      op(3'h1, 8'hFF, 1'h0);
      op(3'h1, 8'hFF, 1'h1);
      op(3'h5, 8'h00, 1'h0);
      op(3'h1, 8'h70, 1'h0);
      rdb("status after reset", 8'hC0);
      apb(1'h0, 12'h010, 32'h0000_0000);
      chk("last command", q, 32'h0000_0070);
      apb(1'h0, 12'h020, 32'h0000_0000);
      chk("unmapped refusal", e, 1'h1);
   endtask
   task automatic t_full;
      op(3'h1, 8'h80, 1'h0);
      a3(8'h00);
      for (int i = 0; i < 528; i++) op(3'h3, i[7:0], 1'h0);
      op(3'h3, 8'hEE, 1'h1);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      t_pwr;
      t_id;
      t_prog;
      t_spare;
      t_nodata;
      t_erase;
      t_rst;
      t_full;
      test_done;
   end
endmodule // tb_nfc_host
